// ===== hdl/csrs_top.sv
// Clock source selection, system clock divider and reset cause status.
// Assumes oscillator and reset inputs are asynchronous levels sampled on
// mclk_i; source clocks must be well below half the mclk_i rate.
//
// Summary of operation
// (R1) Trim field 8 bits, resets to 0x80
// (R2) Bits 0,1 flag power-on and pin reset
// (R3) Bits 2,3,4 flag watchdog, brownout, software reset
// (R4) Write one clears a flag, zero keeps
// (R5) Power-on reset clears all other flags
// (R6) Source still asserted after power-on sets flag
// (R7) Only power-on reset zeroes the flags
// (R8) PLL input: 0 RC, 1 crystal, 3 pin
// (R9) PLL selection applies on update zero-to-one
// (R10) Main: RC, PLL input, watchdog osc, PLL out
// (R11) Main selection applies on update zero-to-one
// (R12) System clock is main divided by 1..255
// (R13) Divisor zero stops the system clock
// (R14) Software programs watchdog osc before selecting it
// (R15) Source switching is free of runt pulses
`timescale 1ns/1ps
`include "csrs_consts.svh"

module csrs_top
    import csrs_pkg::*;
#(
    parameter int unsigned DIV_W = 8  // System divider width
) (
    input  wire logic              mclk_i,          // Register clock
    input  wire logic              rst_n_i,         // Power-on reset
    input  wire csrs_req_t         reg_req_i,       // Register request
    output logic [31:0]            reg_rdata_o,     // Read data, next cycle
    input  wire logic              rc_clk_i,        // RC oscillator level
    input  wire logic              xtal_clk_i,      // Crystal oscillator level
    input  wire logic              ext_clk_pin_i,   // External clock pin
    input  wire logic              wdosc_clk_i,     // Watchdog oscillator
    input  wire logic              pll_out_clk_i,   // PLL output
    input  wire logic              pin_reset_i,     // Pin reset level
    input  wire logic              wdt_reset_i,     // Watchdog reset level
    input  wire logic              bod_reset_i,     // Brownout reset level
    input  wire logic              sw_reset_i,      // Software reset level
    output logic [7:0]             rc_trim_o,       // Oscillator trim
    output logic                   pll_in_clk_o,    // PLL input clock
    output logic                   main_clk_o,      // Main clock
    output logic                   sys_clk_o,       // System clock
    output logic                   irq_o            // Interrupt level
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------

    // Pick one of four source levels
    function automatic logic pick4(input logic [3:0] lv, input logic [1:0] sel);
        pick4 = lv[sel];
    endfunction : pick4

    // Write to one address
    function automatic logic wr_hit(input csrs_req_t rq, input logic [31:0] a);
        wr_hit = rq.we && (rq.addr == a);
    endfunction : wr_hit

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [8:0] sync1_q;   // First stage, read only by second
    logic [8:0] sync2_q;   // Second stage
    logic [8:0] raw_in;    // Raw asynchronous levels

    assign raw_in = {sw_reset_i, bod_reset_i, wdt_reset_i, pin_reset_i, pll_out_clk_i,
                     wdosc_clk_i, ext_clk_pin_i, xtal_clk_i, rc_clk_i};

    // Two flops before any use
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sync1_q <= 9'h000;
            sync2_q <= 9'h000;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    logic       rc_s;     // Synchronised RC level
    logic [3:0] rst_src;  // Pin, watchdog, brownout, software
    assign rc_s    = sync2_q[0];
    assign rst_src = sync2_q[8:5];

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0]       trim_q;      // Trim value
    logic [4:0]       cause_q;     // Reset cause flags
    logic             por_pend_q;  // Power-on seen, flag pending
    logic [1:0]       pll_sel_q;   // Requested PLL source
    logic [1:0]       main_sel_q;  // Requested main source
    logic             pll_upd_q;   // PLL update bit
    logic             main_upd_q;  // Main update bit
    logic [DIV_W-1:0] div_q;       // System divider
    logic [1:0]       ev_q;        // Switch event status
    logic [1:0]       mask_q;      // Event mask

    logic pll_go;   // PLL update written zero to one
    logic main_go;  // Main update written zero to one

    // Update strobe edge: a one written while the bit holds zero
    assign pll_go  = wr_hit(reg_req_i, `CSRS_ADDR_PLL_UPD) && reg_req_i.wdata[`CSRS_BIT_UPD]
                     && !pll_upd_q;                                               // [R9]
    assign main_go = wr_hit(reg_req_i, `CSRS_ADDR_MAIN_UPD) && reg_req_i.wdata[`CSRS_BIT_UPD]
                     && !main_upd_q;                                              // [R11]

    // Plain read/write registers
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            trim_q     <= `CSRS_RST_TRIM;                                         // [R1]
            pll_sel_q  <= `CSRS_RST_SEL;
            main_sel_q <= `CSRS_RST_SEL;
            pll_upd_q  <= 1'b0;
            main_upd_q <= 1'b0;
            div_q      <= DIV_W'(`CSRS_RST_DIV);
            mask_q     <= 2'b00;
        end else begin
            if (wr_hit(reg_req_i, `CSRS_ADDR_RC_TRIM))
                trim_q <= reg_req_i.wdata[7:0];                                   // [R1]
            if (wr_hit(reg_req_i, `CSRS_ADDR_PLL_SEL))
                pll_sel_q <= reg_req_i.wdata[1:0];                                // [R8]
            if (wr_hit(reg_req_i, `CSRS_ADDR_MAIN_SEL))
                main_sel_q <= reg_req_i.wdata[1:0];                               // [R10]
            if (wr_hit(reg_req_i, `CSRS_ADDR_PLL_UPD))
                pll_upd_q <= reg_req_i.wdata[`CSRS_BIT_UPD];
            if (wr_hit(reg_req_i, `CSRS_ADDR_MAIN_UPD))
                main_upd_q <= reg_req_i.wdata[`CSRS_BIT_UPD];
            if (wr_hit(reg_req_i, `CSRS_ADDR_SYS_DIV))
                div_q <= reg_req_i.wdata[DIV_W-1:0];                              // [R12]
            if (wr_hit(reg_req_i, `CSRS_ADDR_IRQ_MASK))
                mask_q <= reg_req_i.wdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // Reset cause flags
    // ------------------------------------------------------------------

    // Only power-on reset zeroes; detection wins over a clearing write
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cause_q    <= 5'h00;                                                  // [R5] [R7]
            por_pend_q <= 1'b1;
        end else begin
            por_pend_q <= 1'b0;
            if (wr_hit(reg_req_i, `CSRS_ADDR_RST_CAUSE))
                cause_q <= cause_q & ~reg_req_i.wdata[4:0];                       // [R4]
            // Sources still held after power-on release keep setting
            if (por_pend_q)
                cause_q[`CSRS_BIT_POR] <= 1'b1;                                   // [R2]
            if (rst_src[0])
                cause_q[`CSRS_BIT_PIN] <= 1'b1;                                   // [R2] [R6]
            if (rst_src[1])
                cause_q[`CSRS_BIT_WDT] <= 1'b1;                                   // [R3] [R6]
            if (rst_src[2])
                cause_q[`CSRS_BIT_BOD] <= 1'b1;                                   // [R3] [R6]
            if (rst_src[3])
                cause_q[`CSRS_BIT_SWR] <= 1'b1;                                   // [R3] [R6]
        end
    end

    // ------------------------------------------------------------------
    // PLL input switch
    // ------------------------------------------------------------------
    csrs_sw_t   pll_sw_q;   // Switch state
    logic [1:0] pll_tgt_q;  // Selection latched at update
    logic [1:0] pll_act_q;  // Source in use
    logic       pll_clk_q;  // Output level
    logic [3:0] pll_lv;     // Source levels; reserved code reads low
    logic       pll_done;   // Switch completes now

    assign pll_lv   = {sync2_q[2], 1'b0, sync2_q[1], rc_s};                      // [R8]
    assign pll_done = (pll_sw_q == CSRS_SW_WAIT) && !pll_clk_q && !pick4(pll_lv, pll_tgt_q);

    // Move only while old output and new source are both low
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pll_sw_q  <= CSRS_SW_IDLE;
            pll_tgt_q <= `CSRS_RST_SEL;
            pll_act_q <= `CSRS_RST_SEL;
        end else begin
            unique case (pll_sw_q)
                CSRS_SW_IDLE: begin
                    if (pll_go) begin
                        pll_tgt_q <= pll_sel_q;                                   // [R9]
                        pll_sw_q  <= CSRS_SW_WAIT;
                    end
                end
                CSRS_SW_WAIT: begin
                    if (pll_go)
                        pll_tgt_q <= pll_sel_q;
                    else if (pll_done) begin
                        pll_act_q <= pll_tgt_q;                                   // [R15]
                        pll_sw_q  <= CSRS_SW_IDLE;
                    end
                end
            endcase
        end
    end

    // Output follows the active source
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i)
            pll_clk_q <= 1'b0;
        else
            pll_clk_q <= pick4(pll_lv, pll_done ? pll_tgt_q : pll_act_q);        // [R15]
    end

    // ------------------------------------------------------------------
    // Main clock switch
    // ------------------------------------------------------------------
    csrs_sw_t   main_sw_q;   // Switch state
    logic [1:0] main_tgt_q;  // Selection latched at update
    logic [1:0] main_act_q;  // Source in use
    logic       main_clk_q;  // Output level
    logic       main_prev_q; // Previous output level
    logic [3:0] main_lv;     // Source levels
    logic       main_done;   // Switch completes now

    assign main_lv   = {sync2_q[4], sync2_q[3], pll_clk_q, rc_s};                // [R10]
    assign main_done = (main_sw_q == CSRS_SW_WAIT) && !main_clk_q && !pick4(main_lv, main_tgt_q);

    // Same guarded switch as the PLL input
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            main_sw_q  <= CSRS_SW_IDLE;
            main_tgt_q <= `CSRS_RST_SEL;
            main_act_q <= `CSRS_RST_SEL;
        end else begin
            unique case (main_sw_q)
                CSRS_SW_IDLE: begin
                    if (main_go) begin
                        main_tgt_q <= main_sel_q;                                 // [R11]
                        main_sw_q  <= CSRS_SW_WAIT;
                    end
                end
                CSRS_SW_WAIT: begin
                    if (main_go)
                        main_tgt_q <= main_sel_q;
                    else if (main_done) begin
                        main_act_q <= main_tgt_q;                                 // [R15]
                        main_sw_q  <= CSRS_SW_IDLE;
                    end
                end
            endcase
        end
    end

    // Main output and edge history
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            main_clk_q  <= 1'b0;
            main_prev_q <= 1'b0;
        end else begin
            main_clk_q  <= pick4(main_lv, main_done ? main_tgt_q : main_act_q);  // [R15]
            main_prev_q <= main_clk_q;
        end
    end

    // ------------------------------------------------------------------
    // System clock divider
    // ------------------------------------------------------------------
    logic [DIV_W-1:0] cnt_q;  // Main period index
    logic [DIV_W:0]   cnt_nx; // Next index, one bit wider

    assign cnt_nx = {1'b0, cnt_q} + {{DIV_W{1'b0}}, 1'b1};

    // Advance on main falling edge so the high phase never shifts
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i)
            cnt_q <= '0;
        else if (div_q == '0)
            cnt_q <= '0;                                                          // [R13]
        else if (main_prev_q && !main_clk_q)
            cnt_q <= (cnt_nx >= {1'b0, div_q}) ? '0 : cnt_nx[DIV_W-1:0];          // [R12]
    end

    logic sys_clk_q;  // System clock level

    // One main high phase out of every divisor periods
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i)
            sys_clk_q <= 1'b0;
        else
            sys_clk_q <= (div_q != '0) && main_clk_q && (cnt_q == '0);            // [R12] [R13]
    end

    // ------------------------------------------------------------------
    // Interrupts: switch-complete events
    // ------------------------------------------------------------------

    // Completion sets, write one clears, set wins
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i)
            ev_q <= 2'b00;
        else
            ev_q <= (ev_q & ~(wr_hit(reg_req_i, `CSRS_ADDR_IRQ_STAT) ? reg_req_i.wdata[1:0] : 2'b00))
                    | {main_done && !main_go, pll_done && !pll_go};
    end

    logic irq_q;  // Interrupt level

    // Any unmasked event raises the line
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i)
            irq_q <= 1'b0;
        else
            irq_q <= |(ev_q & mask_q);
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    logic [31:0] rdata_q;  // Read data, valid one cycle
    logic [31:0] rd_mux;   // Selected register

    // Unmapped addresses read zero
    always_comb begin
        unique case (reg_req_i.addr)
            `CSRS_ADDR_RC_TRIM:   rd_mux = {24'h00_0000, trim_q};
            `CSRS_ADDR_RST_CAUSE: rd_mux = {27'h000_0000, cause_q};
            `CSRS_ADDR_PLL_SEL:   rd_mux = {30'h0000_0000, pll_sel_q};
            `CSRS_ADDR_PLL_UPD:   rd_mux = {31'h0000_0000, pll_upd_q};
            `CSRS_ADDR_MAIN_SEL:  rd_mux = {30'h0000_0000, main_sel_q};
            `CSRS_ADDR_MAIN_UPD:  rd_mux = {31'h0000_0000, main_upd_q};
            `CSRS_ADDR_SYS_DIV:   rd_mux = 32'(div_q);
            `CSRS_ADDR_IRQ_STAT:  rd_mux = {30'h0000_0000, ev_q};
            `CSRS_ADDR_IRQ_MASK:  rd_mux = {30'h0000_0000, mask_q};
            default:              rd_mux = 32'h0000_0000;
        endcase
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i)
            rdata_q <= 32'h0000_0000;
        else
            rdata_q <= reg_req_i.re ? rd_mux : 32'h0000_0000;
    end

    assign reg_rdata_o  = rdata_q;
    assign rc_trim_o    = trim_q;
    assign pll_in_clk_o = pll_clk_q;
    assign main_clk_o   = main_clk_q;
    assign sys_clk_o    = sys_clk_q;
    assign irq_o        = irq_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_por_release;
        $rose(rst_n_i);
    endsequence

    sequence s_pll_ready;
        (pll_sw_q == CSRS_SW_WAIT) && !pll_go ##0 pll_done;
    endsequence

    sequence s_main_ready;
        (main_sw_q == CSRS_SW_WAIT) && !main_go ##0 main_done;
    endsequence

    AST_TRIM_RESET: assert property (s_por_release |-> rc_trim_o == 8'h80)       // [R1]
        else $error("Trim not at reset value");
    AST_POR_FLAG: assert property (s_por_release |=> cause_q[0])                 // [R2]
        else $error("Power-on flag not set");
    AST_WDT_FLAG: assert property (rst_src[1] |=> cause_q[2])                    // [R3]
        else $error("Watchdog flag not set");
    AST_W1C_CLEAR: assert property (wr_hit(reg_req_i, `CSRS_ADDR_RST_CAUSE)       // [R4]
        && reg_req_i.wdata[3] && !rst_src[2] |=> !cause_q[3])
        else $error("Brownout flag not cleared");
    AST_W0_KEEP: assert property (wr_hit(reg_req_i, `CSRS_ADDR_RST_CAUSE)         // [R4]
        && !reg_req_i.wdata[4] && cause_q[4] |=> cause_q[4])
        else $error("Flag lost on zero write");
    AST_POR_CLEARS: assert property (s_por_release |-> cause_q[4:1] == 4'h0)     // [R5]
        else $error("Flags not zero after power-on");
    AST_PIN_HELD: assert property (s_por_release ##0 pin_reset_i [*3] |=> ##0    // [R6]
        cause_q[1])
        else $error("Held pin reset not flagged");
    AST_NO_ZERO: assert property (cause_q[2] && !wr_hit(reg_req_i, `CSRS_ADDR_RST_CAUSE) // [R7]
        |=> cause_q[2])
        else $error("Flags zeroed without power-on");
    AST_PLL_SWITCH: assert property (s_pll_ready |=> pll_act_q == $past(pll_tgt_q)) // [R8] [R9]
        else $error("PLL input did not switch");
    AST_PLL_HOLD: assert property (pll_sw_q == CSRS_SW_IDLE && !pll_go           // [R9]
        |=> $stable(pll_act_q))
        else $error("PLL input moved without update");
    AST_MAIN_SWITCH: assert property (s_main_ready |=> main_act_q == $past(main_tgt_q)) // [R10] [R11]
        else $error("Main clock did not switch");
    AST_DIV1: assert property (div_q == 8'h01 && cnt_q == '0                     // [R12]
        |=> sys_clk_o == $past(main_clk_q))
        else $error("Divide by one wrong");
    AST_DIV_STOP: assert property (div_q == '0 |=> !sys_clk_o)                   // [R13]
        else $error("System clock runs at divisor zero");
    AST_NO_RUNT: assert property (!($changed(pll_act_q) && pll_clk_q)           // [R15]
        && !($changed(main_act_q) && main_clk_q))
        else $error("Switch left a runt pulse");

endmodule : csrs_top

// ===== hdl/csrs_consts.svh
// Constants for the clock select and reset status block.
// Assumes a 32-bit byte address bus and a 20 MHz register clock.
`ifndef CSRS_CONSTS_SVH
`define CSRS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define CSRS_ADDR_RC_TRIM      32'h4004_8028
`define CSRS_ADDR_RST_CAUSE    32'h4004_8030
`define CSRS_ADDR_PLL_SEL      32'h4004_8040
`define CSRS_ADDR_PLL_UPD      32'h4004_8044
`define CSRS_ADDR_MAIN_SEL     32'h4004_8070
`define CSRS_ADDR_MAIN_UPD     32'h4004_8074
`define CSRS_ADDR_SYS_DIV      32'h4004_8078
`define CSRS_ADDR_IRQ_STAT     32'h4004_8100
`define CSRS_ADDR_IRQ_MASK     32'h4004_8104

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CSRS_RST_TRIM          8'h80
`define CSRS_RST_DIV           8'h01
`define CSRS_RST_SEL           2'h0

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CSRS_BIT_POR           0
`define CSRS_BIT_PIN           1
`define CSRS_BIT_WDT           2
`define CSRS_BIT_BOD           3
`define CSRS_BIT_SWR           4
`define CSRS_BIT_UPD           0
`define CSRS_BIT_EV_PLL        0
`define CSRS_BIT_EV_MAIN       1

`endif

// ===== hdl/csrs_pkg.sv
// Types for the clock select and reset status block.
// Assumes csrs_consts.svh is on the include path.
package csrs_pkg;

    // ------------------------------------------------------------------
    // Register port request
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] addr;   // Byte address
        logic [31:0] wdata;  // Write data
        logic        we;     // Write strobe
        logic        re;     // Read strobe
    } csrs_req_t;

    // Source switch state
    typedef enum logic {
        CSRS_SW_IDLE = 1'b0,
        CSRS_SW_WAIT = 1'b1
    } csrs_sw_t;

    // Main clock source codes
    typedef enum logic [1:0] {
        CSRS_MAIN_RC     = 2'h0,
        CSRS_MAIN_PLLIN  = 2'h1,
        CSRS_MAIN_WDOSC  = 2'h2,
        CSRS_MAIN_PLLOUT = 2'h3
    } csrs_main_src_t;

endpackage : csrs_pkg

// ===== verification/tb_csrs_top.sv
// Self-checking bench for the clock select and reset status block.
// Assumes csrs_pkg and csrs_consts.svh are compiled; no partner model.
`timescale 1ns/1ps
`include "csrs_consts.svh"

module tb_csrs_top;
    import csrs_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic        mclk_i = 1'b0;  // Register clock, 20 MHz
    logic        rst_n_i = 1'b0; // Power-on reset
    csrs_req_t   req = '0;       // Register request
    logic [31:0] rdata;          // Read data
    logic [7:0]  trim;           // Trim output
    logic        rc = 0, xt = 0, ep = 0, wd = 0, po = 0;  // Source clocks
    logic [3:0]  rsrc = '0;      // Pin, watchdog, brownout, software levels
    logic        pllin, mainc, sysc, irq;  // Clock and interrupt outputs
    logic [31:0] exp_q[$];       // Expected read data notes
    logic        re_seen = 1'b0; // Read issued last edge
    int          bad_count = 0, n_checks = 0, seed = 66545, na, ns, np;
    logic [7:0]  tv;             // Random trim value
    logic        pm = 1'b0, ps = 1'b0, pp = 1'b0;  // Previous main, system, PLL input levels

    always #25 mclk_i = ~mclk_i;
    always #110 rc = ~rc;
    always #130 xt = ~xt;
    always #170 ep = ~ep;
    always #190 wd = ~wd;
    always #150 po = ~po;

    csrs_top i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_req_i(req), .reg_rdata_o(rdata),
        .rc_clk_i(rc), .xtal_clk_i(xt), .ext_clk_pin_i(ep), .wdosc_clk_i(wd), .pll_out_clk_i(po),
        .pin_reset_i(rsrc[0]), .wdt_reset_i(rsrc[1]), .bod_reset_i(rsrc[2]), .sw_reset_i(rsrc[3]),
        .rc_trim_o(trim), .pll_in_clk_o(pllin), .main_clk_o(mainc), .sys_clk_o(sysc), .irq_o(irq));

    // ------------------------------------------------------------
    // Compare, bus and closing tasks
    // ------------------------------------------------------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk_i) req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk_i) req <= '0;
    endtask : wr
    task rd(input logic [31:0] a, input logic [31:0] e);
        @(posedge mclk_i) req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        exp_q.push_back(e);
        @(posedge mclk_i) req <= '0;
    endtask : rd
    task cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : cyc
    task pulse(input int b);
        @(posedge mclk_i) rsrc[b] <= 1'b1;
        cyc(4);
        rsrc[b] <= 1'b0;
        cyc(4);
    endtask : pulse
    // Select, then zero-then-one update; the done event must raise irq
    task sw(input logic [31:0] sa, input logic [31:0] ua, input logic [31:0] c, input logic [31:0] ev);
        wr(sa, c);
        wr(ua, 0);
        wr(ua, 1);
        for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge mclk_i);
        chk("irq", 1, irq);
        rd(`CSRS_ADDR_IRQ_STAT, ev);
        wr(`CSRS_ADDR_IRQ_STAT, 3);
        cyc(3);
    endtask : sw
    task stop_test;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // Read data monitor: oldest note against data one cycle on
    // ------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (re_seen) chk("rdata", exp_q.pop_front(), rdata);
        re_seen <= req.re;
    end

    initial begin
        #(30000 * 50);
        bad_count++;
        stop_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(16);
        rst_n_i <= 1'b1;
        cyc(3);
        rd(`CSRS_ADDR_RC_TRIM, 32'h0000_0080);
        rd(`CSRS_ADDR_SYS_DIV, 32'h0000_0001);
        rd(`CSRS_ADDR_PLL_SEL, 0);
        rd(`CSRS_ADDR_MAIN_SEL, 0);
        rd(32'h4004_8200, 0);
        rd(`CSRS_ADDR_RST_CAUSE, 32'h0000_0001);
        for (int b = 0; b < 4; b++) pulse(b);
        rd(`CSRS_ADDR_RST_CAUSE, 32'h0000_001F);
        wr(`CSRS_ADDR_RST_CAUSE, 32'h0000_000A);
        wr(`CSRS_ADDR_RST_CAUSE, 0);
        rd(`CSRS_ADDR_RST_CAUSE, 32'h0000_0015);
        pulse(0);
        rd(`CSRS_ADDR_RST_CAUSE, 32'h0000_0017);
        tv = 8'($random(seed));
        wr(`CSRS_ADDR_RC_TRIM, {24'h00_0000, tv});
        rd(`CSRS_ADDR_RC_TRIM, {24'h00_0000, tv});
        cyc(2);
        chk("trim", {24'h00_0000, tv}, {24'h00_0000, trim});
        wr(`CSRS_ADDR_IRQ_MASK, 3);
        sw(`CSRS_ADDR_PLL_SEL, `CSRS_ADDR_PLL_UPD, 1, 1);
        sw(`CSRS_ADDR_PLL_SEL, `CSRS_ADDR_PLL_UPD, 3, 1);
        sw(`CSRS_ADDR_PLL_SEL, `CSRS_ADDR_PLL_UPD, 0, 1);
        // Watchdog source runs from time zero here, so its rate is set before use
        for (int s = 1; s < 5; s++) sw(`CSRS_ADDR_MAIN_SEL, `CSRS_ADDR_MAIN_UPD, s % 4, 2);
        wr(`CSRS_ADDR_MAIN_SEL, 2);
        wr(`CSRS_ADDR_MAIN_UPD, 1);
        cyc(60);
        chk("irq", 0, irq);
        rd(`CSRS_ADDR_MAIN_SEL, 2);
        wr(`CSRS_ADDR_SYS_DIV, 0);
        cyc(4);
        ns = 0;
        repeat (100) @(posedge mclk_i) ns += sysc;
        chk("sysclk_off", 0, ns);
        wr(`CSRS_ADDR_SYS_DIV, 3);
        cyc(4);
        na = 0;
        ns = 0;
        np = 0;
        repeat (600) begin
            @(posedge mclk_i);
            na += (mainc && !pm);
            ns += (sysc && !ps);
            np += (pllin && !pp);
            pm = mainc;
            ps = sysc;
            pp = pllin;
        end
        chk("sysclk_div", 1, (ns >= na / 3 - 1) && (ns <= na / 3 + 1));
        // PLL input and main clock both run from the RC source here
        chk("pll_in", 1, (np >= na - 1) && (np <= na + 1));
        @(posedge mclk_i) rsrc[0] <= 1'b1;
        rst_n_i <= 1'b0;
        cyc(16);
        rst_n_i <= 1'b1;
        cyc(6);
        rsrc[0] <= 1'b0;
        cyc(4);
        rd(`CSRS_ADDR_RST_CAUSE, 32'h0000_0003);
        cyc(3);
        stop_test();
    end
endmodule : tb_csrs_top
